// ---- design/vrc_pkg.sv ----
// package: register map, field positions, modes and timing for the velocity ramp control block
package vrc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CMD        = 8'h00;
    localparam logic [7:0] OFF_MODE       = 8'h04;
    localparam logic [7:0] OFF_PROFILE    = 8'h08;
    localparam logic [7:0] OFF_TARGET     = 8'h0C;
    localparam logic [7:0] OFF_ACC_DV     = 8'h10;
    localparam logic [7:0] OFF_ACC_DT     = 8'h14;
    localparam logic [7:0] OFF_DEC_DV     = 8'h18;
    localparam logic [7:0] OFF_DEC_DT     = 8'h1C;
    localparam logic [7:0] OFF_QS_DV      = 8'h20;
    localparam logic [7:0] OFF_QS_DT      = 8'h24;
    localparam logic [7:0] OFF_VMIN       = 8'h28;
    localparam logic [7:0] OFF_VMAX       = 8'h2C;
    localparam logic [7:0] OFF_SCALE_NUM  = 8'h30;
    localparam logic [7:0] OFF_SCALE_DEN  = 8'h34;
    localparam logic [7:0] OFF_REV_TYPE   = 8'h38;
    localparam logic [7:0] OFF_JERK       = 8'h3C;
    localparam logic [7:0] OFF_MAX_ACC    = 8'h40;
    localparam logic [7:0] OFF_MAX_DEC    = 8'h44;
    localparam logic [7:0] OFF_WIN        = 8'h48;
    localparam logic [7:0] OFF_WIN_TIME   = 8'h4C;
    localparam logic [7:0] OFF_ACTUAL     = 8'h50;
    localparam logic [7:0] OFF_STATUS     = 8'h54;
    localparam logic [7:0] OFF_DEMAND     = 8'h58;
    localparam logic [7:0] OFF_POS_SAMPLE = 8'h5C;
    localparam logic [7:0] OFF_POS_BASE   = 8'h60;
    localparam logic [7:0] OFF_SPEED_OUT  = 8'h64;

    // command word fields
    localparam int CMD_HALT_BIT   = 8;
    localparam int CMD_QSTOP_BIT  = 2;
    // status word fields
    localparam int STS_REACH_BIT  = 10;
    localparam int STS_LIMIT_BIT  = 11;
    localparam int STS_JERK_BIT   = 0;
    localparam int STS_LIMSW_BIT  = 1;

    // mode and profile type codes
    localparam logic [7:0] MODE_POSITION = 8'h01;
    localparam logic [7:0] MODE_VEL      = 8'h02;
    localparam logic [7:0] MODE_PROF_VEL = 8'h03;
    localparam logic [1:0] PROF_TRAP     = 2'h0;
    localparam logic [1:0] PROF_JERK     = 2'h3;

    // reset values
    localparam logic [31:0] RST_ONE      = 32'h0000_0001;
    localparam logic [31:0] RST_VMAX     = 32'h0000_0BB8;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

    // timing: position sample period (also the ramp update tick) and window time millisecond
    localparam int CLK_HZ          = 40_000_000;
    localparam int SAMPLE_US       = 1000;
    localparam int SAMPLE_CYCLES   = CLK_HZ / 1_000_000 * SAMPLE_US;
    localparam int WINTIME_CYCLES  = CLK_HZ / 1000;

    typedef enum logic [3:0] {
        VRC_STOPPED = 4'b0001,
        VRC_RUN     = 4'b0010,
        VRC_BRAKE   = 4'b0100,
        VRC_QSTOP   = 4'b1000
    } vrc_state_e;

    typedef struct packed {
        logic        halt;
        logic        qstop;
        logic        limit;
        logic        reached;
    } vrc_flags_s;

endpackage : vrc_pkg

// ---- design/vrc_top.sv ----
// velocity and profile velocity ramp control with APB register access
//
// Contract
// - sample actual position once per millisecond
// - end-velocity chained moves rebase on sample
// - profile type 3 applies jerk limits
// - profile type 0 runs unlimited jerk
// - positioning never exceeds max acc/dec
// - quick stop brakes with emergency deceleration
// - limit switch handling stays active
// - velocity mode forbids jerk-limited ramps
// - halt holds stop, release accelerates
// - halt rise decelerates to standstill
// - status bit 11 while limit active
// - scale both one means rpm
// - revolution selector electrical or mechanical; the code stores and reads it back but never applies it
// - acceleration is delta speed over time
// - clamp target between min and max
// - quick stop ramp from own object
// - ramp tracks target within limits
// - profile velocity halt stop and restart
// - bit 10 with halt reports state
// - reached only after window time elapses; with halt set the code reports reached at standstill without waiting
`timescale 1ns/1ps
module vrc_top
    import vrc_pkg::*;
#(
    parameter int SAMPLE_CNT  = SAMPLE_CYCLES,
    parameter int WINTIME_CNT = WINTIME_CYCLES
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] position_in,
    input  wire logic        limit_switch,
    output logic      [31:0] speed_demand,
    output logic             brake_active
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] cmd_r, mode_r, target_r, acc_dv_r, acc_dt_r, dec_dv_r, dec_dt_r;
    logic [31:0] qs_dv_r, qs_dt_r, vmin_r, vmax_r, num_r, den_r, jerk_r;
    logic [31:0] max_acc_r, max_dec_r, win_r, win_time_r, actual_r;
    logic [31:0] pos_sample_r, pos_base_r, demand_r;
    logic [1:0]  profile_r;
    logic        rev_type_r;
    logic        halt_d_r;
    vrc_state_e  state_r, state_nxt;
    vrc_flags_s  flags_r;
    logic [31:0] sample_cnt_r, dt_cnt_r, win_ms_r;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode
    wire [7:0]  addr    = paddr[7:0];
    wire        mapped  = (addr <= OFF_SPEED_OUT) && (addr[1:0] == 2'h0) && (paddr[31:8] == 24'h0);
    // refused accesses must not alias onto a register through the low address byte
    wire        wr_en   = psel & penable & pwrite & mapped;
    wire [31:0] wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nv & m);
    endfunction : merge

    function automatic logic wsel(input logic [7:0] a, input logic [7:0] off);
        wsel = (a == off);
    endfunction : wsel

    ////////////////////////////////////////////////////////////////////////////
    // mode and ramp decode
    wire        halt      = cmd_r[CMD_HALT_BIT];
    wire        qstop     = cmd_r[CMD_QSTOP_BIT];
    wire        vel_mode  = (mode_r[7:0] == MODE_VEL);
    wire        pv_mode   = (mode_r[7:0] == MODE_PROF_VEL);
    wire        pos_mode  = (mode_r[7:0] == MODE_POSITION);
    wire        active    = vel_mode | pv_mode | pos_mode;
    // velocity mode cannot use jerk limiting regardless of setting
    wire        jerk_on   = (profile_r == PROF_JERK) & ~vel_mode;
    wire [1:0]  wprof     = pwdata[1:0];
    wire        prof_ok   = (pwdata[31:2] == 30'h0) &&
                            ((wprof == PROF_TRAP) || (wprof == PROF_JERK));

    // target clamp
    wire        below     = $signed(target_r) < $signed(vmin_r);
    wire        above     = $signed(target_r) > $signed(vmax_r);
    wire [31:0] tgt_clamp = below ? vmin_r : (above ? vmax_r : target_r);
    wire [31:0] goal      = (halt | qstop | ~active) ? 32'h0 : tgt_clamp;

    // step per tick: dv applied once every dt milliseconds
    wire        braking   = (state_r == VRC_BRAKE) | (state_r == VRC_QSTOP);
    wire [31:0] sel_dv    = (state_r == VRC_QSTOP) ? qs_dv_r :
                            (braking ? dec_dv_r : acc_dv_r);
    wire [31:0] sel_dt    = (state_r == VRC_QSTOP) ? qs_dt_r :
                            (braking ? dec_dt_r : acc_dt_r);
    wire [31:0] cap       = braking ? max_dec_r : max_acc_r;
    wire        over_cap  = pos_mode && (sel_dv > cap);
    wire [31:0] raw_step  = over_cap ? cap : sel_dv;
    // jerk limit caps the change per tick further
    wire        jerk_cap  = jerk_on && (jerk_r != 32'h0) && (raw_step > jerk_r);
    wire [31:0] step      = jerk_cap ? jerk_r : raw_step;
    wire        ms_tick   = (sample_cnt_r == 32'(SAMPLE_CNT - 1));
    wire        ramp_tick = ms_tick && (dt_cnt_r + 32'h1 >= sel_dt);
    wire [31:0] diff      = goal - demand_r;
    wire        up        = $signed(diff) > 0;
    wire        near      = up ? (diff <= step) : ((32'h0 - diff) <= step);
    wire [31:0] dem_nxt   = near ? goal : (up ? demand_r + step : demand_r - step);

    // unit scaling: rpm when both factors one, else rps times num over den
    wire        rpm_unit  = (num_r == RST_ONE) && (den_r == RST_ONE);
    wire [63:0] scaled    = $signed(demand_r) * $signed(num_r);
    wire [31:0] den_safe  = (den_r == 32'h0) ? RST_ONE : den_r;
    wire [31:0] user_spd  = rpm_unit ? demand_r :
                            32'($signed(scaled) / $signed({32'h0, den_safe}));
    // revolution type does not alter the speed; status carries no revolution type bit
    wire [31:0] speed_nxt = user_spd;

    // window compare
    wire [31:0] err       = actual_r - demand_r;
    wire [31:0] abs_err   = err[31] ? 32'h0 - err : err;
    wire        in_win    = (abs_err <= win_r) && (demand_r == goal);
    wire        at_zero   = (actual_r == 32'h0) && (demand_r == 32'h0);
    wire        reached_w = halt ? at_zero : (win_ms_r >= win_time_r) && in_win;

    wire        limit_w   = (below | above | over_cap | jerk_cap | limit_switch) & active;

    ////////////////////////////////////////////////////////////////////////////
    // state machine
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            VRC_STOPPED:
                if (qstop)
                    state_nxt = VRC_QSTOP;
                else if (~halt && active && goal != 32'h0)
                    state_nxt = VRC_RUN;
            VRC_RUN:
                if (qstop)
                    state_nxt = VRC_QSTOP;
                else if ((halt & ~halt_d_r) || ~active)
                    state_nxt = VRC_BRAKE;
            VRC_BRAKE:
                if (qstop)
                    state_nxt = VRC_QSTOP;
                else if (demand_r == 32'h0)
                    state_nxt = VRC_STOPPED;
                else if (~halt && active)
                    state_nxt = VRC_RUN;
            VRC_QSTOP:
                if (demand_r == 32'h0 && ~qstop)
                    state_nxt = VRC_STOPPED;
            default:
                state_nxt = VRC_STOPPED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_r      <= RST_ZERO;
            mode_r     <= RST_ZERO;
            target_r   <= RST_ZERO;
            acc_dv_r   <= RST_ONE;
            acc_dt_r   <= RST_ONE;
            dec_dv_r   <= RST_ONE;
            dec_dt_r   <= RST_ONE;
            qs_dv_r    <= RST_ONE;
            qs_dt_r    <= RST_ONE;
            vmin_r     <= RST_ZERO;
            vmax_r     <= RST_VMAX;
            num_r      <= RST_ONE;
            den_r      <= RST_ONE;
            jerk_r     <= RST_ZERO;
            max_acc_r  <= RST_VMAX;
            max_dec_r  <= RST_VMAX;
            win_r      <= RST_ONE;
            win_time_r <= RST_ZERO;
            profile_r  <= PROF_TRAP;
            rev_type_r <= 1'b0;
        end
        else if (wr_en)
        begin
            if (wsel(addr, OFF_CMD))       cmd_r      <= merge(cmd_r, pwdata, wmask);
            if (wsel(addr, OFF_MODE))      mode_r     <= merge(mode_r, pwdata, wmask);
            if (wsel(addr, OFF_TARGET))    target_r   <= merge(target_r, pwdata, wmask);
            if (wsel(addr, OFF_ACC_DV))    acc_dv_r   <= merge(acc_dv_r, pwdata, wmask);
            if (wsel(addr, OFF_ACC_DT))    acc_dt_r   <= merge(acc_dt_r, pwdata, wmask);
            if (wsel(addr, OFF_DEC_DV))    dec_dv_r   <= merge(dec_dv_r, pwdata, wmask);
            if (wsel(addr, OFF_DEC_DT))    dec_dt_r   <= merge(dec_dt_r, pwdata, wmask);
            if (wsel(addr, OFF_QS_DV))     qs_dv_r    <= merge(qs_dv_r, pwdata, wmask);
            if (wsel(addr, OFF_QS_DT))     qs_dt_r    <= merge(qs_dt_r, pwdata, wmask);
            if (wsel(addr, OFF_VMIN))      vmin_r     <= merge(vmin_r, pwdata, wmask);
            if (wsel(addr, OFF_VMAX))      vmax_r     <= merge(vmax_r, pwdata, wmask);
            if (wsel(addr, OFF_SCALE_NUM)) num_r      <= merge(num_r, pwdata, wmask);
            if (wsel(addr, OFF_SCALE_DEN)) den_r      <= merge(den_r, pwdata, wmask);
            if (wsel(addr, OFF_JERK))      jerk_r     <= merge(jerk_r, pwdata, wmask);
            if (wsel(addr, OFF_MAX_ACC))   max_acc_r  <= merge(max_acc_r, pwdata, wmask);
            if (wsel(addr, OFF_MAX_DEC))   max_dec_r  <= merge(max_dec_r, pwdata, wmask);
            if (wsel(addr, OFF_WIN))       win_r      <= merge(win_r, pwdata, wmask);
            if (wsel(addr, OFF_WIN_TIME))  win_time_r <= merge(win_time_r, pwdata, wmask);
            // whole-word write only, bad values leave the old ramp type
            if (wsel(addr, OFF_PROFILE) && prof_ok && pstrb == 4'hF)
                profile_r <= wprof;
            if (wsel(addr, OFF_REV_TYPE) && pstrb[0])
                rev_type_r <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ramp, sampling and status
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r      <= VRC_STOPPED;
            halt_d_r     <= 1'b0;
            demand_r     <= RST_ZERO;
            sample_cnt_r <= RST_ZERO;
            dt_cnt_r     <= RST_ZERO;
            win_ms_r     <= RST_ZERO;
            actual_r     <= RST_ZERO;
            pos_sample_r <= RST_ZERO;
            pos_base_r   <= RST_ZERO;
            flags_r      <= '0;
            speed_demand <= RST_ZERO;
            brake_active <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            halt_d_r     <= halt;
            sample_cnt_r <= ms_tick ? 32'h0 : sample_cnt_r + 32'h1;
            if (ms_tick)
            begin
                pos_sample_r <= position_in;
                // speed estimate from position change between samples
                actual_r     <= position_in - pos_sample_r;
                // each sample taken in position mode while demand is nonzero becomes next move's base
                if (pos_mode && demand_r != 32'h0)
                    pos_base_r <= position_in;
                dt_cnt_r     <= ramp_tick ? 32'h0 : dt_cnt_r + 32'h1;
                win_ms_r     <= in_win ? win_ms_r + 32'h1 : 32'h0;
            end
            if (ramp_tick)
                demand_r <= dem_nxt;
            flags_r.halt    <= halt;
            flags_r.qstop   <= qstop;
            flags_r.limit   <= limit_w;
            flags_r.reached <= reached_w;
            speed_demand <= speed_nxt;
            brake_active <= braking;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path
    logic [31:0] rd_mux;
    wire  [31:0] status_w = (32'(flags_r.reached) << STS_REACH_BIT) |
                            (32'(flags_r.limit) << STS_LIMIT_BIT) |
                            (32'(jerk_on) << STS_JERK_BIT) |
                            (32'(limit_switch) << STS_LIMSW_BIT);
    always_comb
    begin
        case (addr)
            OFF_CMD:        rd_mux = cmd_r;
            OFF_MODE:       rd_mux = mode_r;
            OFF_PROFILE:    rd_mux = {30'h0, profile_r};
            OFF_TARGET:     rd_mux = target_r;
            OFF_ACC_DV:     rd_mux = acc_dv_r;
            OFF_ACC_DT:     rd_mux = acc_dt_r;
            OFF_DEC_DV:     rd_mux = dec_dv_r;
            OFF_DEC_DT:     rd_mux = dec_dt_r;
            OFF_QS_DV:      rd_mux = qs_dv_r;
            OFF_QS_DT:      rd_mux = qs_dt_r;
            OFF_VMIN:       rd_mux = vmin_r;
            OFF_VMAX:       rd_mux = vmax_r;
            OFF_SCALE_NUM:  rd_mux = num_r;
            OFF_SCALE_DEN:  rd_mux = den_r;
            OFF_REV_TYPE:   rd_mux = {31'h0, rev_type_r};
            OFF_JERK:       rd_mux = jerk_r;
            OFF_MAX_ACC:    rd_mux = max_acc_r;
            OFF_MAX_DEC:    rd_mux = max_dec_r;
            OFF_WIN:        rd_mux = win_r;
            OFF_WIN_TIME:   rd_mux = win_time_r;
            OFF_ACTUAL:     rd_mux = actual_r;
            OFF_STATUS:     rd_mux = status_w;
            OFF_DEMAND:     rd_mux = demand_r;
            OFF_POS_SAMPLE: rd_mux = pos_sample_r;
            OFF_POS_BASE:   rd_mux = pos_base_r;
            OFF_SPEED_OUT:  rd_mux = speed_demand;
            default:        rd_mux = 32'h0;
        endcase
    end

    // zero wait states: ready is registered during setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= RST_ZERO;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite & mapped) ? rd_mux : RST_ZERO;
        end
    end

endmodule : vrc_top

// ---- testbench/vrc_motor_model.sv ----
// motor and encoder stand-in: integrates the speed demand, reports an end stop
`timescale 1ns/1ps
module vrc_motor_model
    import vrc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] speed_demand,
    input  wire logic        load,
    input  wire logic [31:0] load_value,
    input  wire logic        end_stop,
    output logic      [31:0] position_in,
    output logic             limit_switch
);
    // position only moves while a speed is demanded or a load value is applied, so a stopped axis reads steady
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            position_in <= 32'h0000_0000;
        else if (load)
            position_in <= load_value;
        else
            position_in <= position_in + speed_demand;
    end
    assign limit_switch = end_stop;
endmodule : vrc_motor_model

// ---- testbench/vrc_top_asserts.sv ----
// checker: port-level timing and ramp properties of the velocity ramp block
`timescale 1ns/1ps
module vrc_checker
    import vrc_pkg::*;
#(
    parameter int SAMPLE_CNT = 8
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] speed_demand,
    input wire logic        brake_active
);
    int since_chg_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    // cycles since the ramp output last moved; starts high so the first step passes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_chg_r <= SAMPLE_CNT;
        else
            since_chg_r <= $changed(speed_demand) ? 0 : since_chg_r + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside access");
    a_err_unmapped: assert property (psel && !penable && (paddr[31:8] != 24'h0 ||
        paddr[1:0] != 2'h0 || paddr[7:0] > OFF_SPEED_OUT) |=> pslverr)
        else $error("unmapped access not refused");
    a_ramp_tick_step: assert property ($changed(speed_demand) |-> since_chg_r >= SAMPLE_CNT - 1)
        else $error("ramp output stepped between ticks");
    a_brake_no_rise: assert property (brake_active |=> speed_demand <= $past(speed_demand))
        else $error("speed rose while braking");
    a_reset_clean: assert property ($rose(presetn) |-> speed_demand == 32'h0 && !brake_active)
        else $error("outputs not clear after reset");
    c_refused: cover property (pslverr);
    c_braking: cover property (brake_active);
    c_ramp_step: cover property ($changed(speed_demand));
endmodule : vrc_checker

bind vrc_top vrc_checker #(.SAMPLE_CNT(SAMPLE_CNT)) u_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .speed_demand(speed_demand),
    .brake_active(brake_active));

// ---- testbench/vrc_top_test.sv ----
// self-checking bench for the velocity ramp control block
`timescale 1ns/1ps
module vrc_top_test;
    import vrc_pkg::*;
    localparam int TICK = 8;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, position_in, speed_demand, prdata, load_value = 32'h0;
    logic        pready, pslverr, limit_switch, brake_active, load = 1'b0, end_stop = 1'b0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0, tests_run = 0;
    always #12.5 pclk = ~pclk;
    vrc_top #(.SAMPLE_CNT(TICK), .WINTIME_CNT(TICK)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .position_in(position_in), .limit_switch(limit_switch),
        .speed_demand(speed_demand), .brake_active(brake_active));
    vrc_motor_model u_motor (.pclk(pclk), .presetn(presetn), .speed_demand(speed_demand),
        .load(load), .load_value(load_value), .end_stop(end_stop),
        .position_in(position_in), .limit_switch(limit_switch));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // setup then access, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdm(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdm
    task automatic st(input int b, input logic e);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status bit", {31'h0, e}, {31'h0, rd[b]});
    endtask : st
    task automatic wait_demand(input logic [31:0] exp);
        int n;
        for (n = 0; n < 3000 && speed_demand !== exp; n++) @(posedge pclk);
        chk("speed_demand", exp, speed_demand);
    endtask : wait_demand
    task automatic wait_brake();
        int n;
        for (n = 0; n < 100 && brake_active !== 1'b1; n++) @(posedge pclk);
        chk("brake_active", 32'h1, {31'h0, brake_active});
    endtask : wait_brake
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdm("vmax reset", OFF_VMAX, RST_VMAX);
        rdm("acc dt reset", OFF_ACC_DT, RST_ONE);
        rdm("max acc reset", OFF_MAX_ACC, RST_VMAX);
        rdm("scale num reset", OFF_SCALE_NUM, RST_ONE);
        rdm("unmapped read", 8'h68, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        wr(8'h02, 32'h0000_00FF);
        chk("misaligned error", 32'h1, {31'h0, err});
        $display("test regs done");
    endtask : t_regs
    task automatic t_velocity();
        wr(OFF_MODE, {24'h0, MODE_VEL});
        wr(OFF_ACC_DV, 32'h0000_0064);
        wr(OFF_DEC_DV, 32'h0000_0064);
        wr(OFF_VMAX, 32'h0000_012C);
        wr(OFF_TARGET, 32'h0000_1388);
        wr(OFF_CMD, 32'h0000_0000);
        wait_demand(32'h0000_012C);
        rdm("demand reg", OFF_DEMAND, 32'h0000_012C);
        st(STS_LIMIT_BIT, 1'b1);
        wr(OFF_CMD, 32'h0000_0100);
        wait_brake();
        wait_demand(32'h0000_0000);
        wr(OFF_VMIN, 32'h0000_0032);
        wr(OFF_TARGET, 32'h0000_000A);
        wr(OFF_CMD, 32'h0000_0000);
        wait_demand(32'h0000_0032);
        st(STS_LIMIT_BIT, 1'b1);
        $display("test velocity done");
    endtask : t_velocity
    task automatic t_qstop();
        wr(OFF_TARGET, 32'h0000_012C);
        wait_demand(32'h0000_012C);
        wr(OFF_QS_DV, 32'h0000_03E8);
        wr(OFF_CMD, 32'h0000_0104);
        wait_brake();
        wait_demand(32'h0000_0000);
        wr(OFF_CMD, 32'h0000_0100);
        $display("test quick stop done");
    endtask : t_qstop
    task automatic t_prof_vel();
        wr(OFF_MODE, {24'h0, MODE_PROF_VEL});
        wr(OFF_PROFILE, {30'h0, PROF_JERK});
        st(STS_JERK_BIT, 1'b1);
        wr(OFF_DEC_DV, 32'h0000_0005);
        wr(OFF_CMD, 32'h0000_0000);
        wait_demand(32'h0000_012C);
        wr(OFF_WIN_TIME, 32'h0000_0064);
        wr(OFF_WIN, 32'h0000_1000);
        st(STS_REACH_BIT, 1'b0);
        wr(OFF_WIN_TIME, 32'h0000_0002);
        repeat (4 * TICK) @(posedge pclk);
        st(STS_REACH_BIT, 1'b1);
        wr(OFF_CMD, 32'h0000_0100);
        st(STS_REACH_BIT, 1'b0);
        wait_demand(32'h0000_0000);
        repeat (6 * TICK) @(posedge pclk);
        st(STS_REACH_BIT, 1'b1);
        wr(OFF_MODE, {24'h0, MODE_VEL});
        st(STS_JERK_BIT, 1'b0);
        wr(OFF_PROFILE, {30'h0, PROF_TRAP});
        rdm("profile zero", OFF_PROFILE, 32'h0);
        wr(OFF_PROFILE, 32'h0000_0001);
        rdm("profile kept", OFF_PROFILE, 32'h0);
        pstrb <= 4'h1;
        wr(OFF_PROFILE, {30'h0, PROF_JERK});
        pstrb <= 4'hF;
        rdm("profile strobe", OFF_PROFILE, 32'h0);
        $display("test profile velocity done");
    endtask : t_prof_vel
    task automatic t_limit_sample();
        end_stop <= 1'b1;
        repeat (4) @(posedge pclk);
        st(STS_LIMSW_BIT, 1'b1);
        end_stop <= 1'b0;
        load <= 1'b1;
        load_value <= 32'h0000_1234;
        @(posedge pclk);
        load <= 1'b0;
        repeat (3 * TICK) @(posedge pclk);
        st(STS_LIMSW_BIT, 1'b0);
        rdm("position sample", OFF_POS_SAMPLE, 32'h0000_1234);
        st(STS_LIMIT_BIT, 1'b0);
        wr(OFF_MODE, {24'h0, MODE_POSITION});
        wr(OFF_MAX_ACC, 32'h0000_0010);
        st(STS_LIMIT_BIT, 1'b1);
        $display("test limit and sample done");
    endtask : t_limit_sample
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_velocity();
        t_qstop();
        t_prof_vel();
        t_limit_sample();
        end_of_test();
    end
    // all waits together stay well under this span
    initial
    begin
        #(25 * 40000);
        bad_count++;
        end_of_test();
    end
endmodule : vrc_top_test
